// file: pkg/rtc_pkg.sv
package rtc_pkg;

    // Register bus geometry
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;  // Mode, method, send style
    localparam logic [7:0] OFS_SETPT  = 8'h04;  // Setpoint, 0.1 K signed
    localparam logic [7:0] OFS_HYST   = 8'h08;  // Heat and cool hysteresis, 0.1 K
    localparam logic [7:0] OFS_PBAND  = 8'h0C;  // Proportional band, 0.1 K
    localparam logic [7:0] OFS_ITIME  = 8'h10;  // Integral time, ticks
    localparam logic [7:0] OFS_CYCLE  = 8'h14;  // Pulse-width cycle, ticks
    localparam logic [7:0] OFS_SENDP  = 8'h18;  // Cyclic send period, ticks
    localparam logic [7:0] OFS_STATUS = 8'h1C;  // Read-only state

    // Control register fields
    localparam int CTRL_OPM_LSB  = 0;  // Two bits
    localparam int CTRL_METH_LSB = 2;  // Two bits
    localparam int CTRL_CYC_BIT  = 4;  // One: cyclic, zero: on event

    // Operation modes
    localparam logic [1:0] OPM_HEAT = 2'h0;
    localparam logic [1:0] OPM_COOL = 2'h1;
    localparam logic [1:0] OPM_AUTO = 2'h2;

    // Control methods
    localparam logic [1:0] METH_TWOPT = 2'h0;
    localparam logic [1:0] METH_PI    = 2'h1;
    localparam logic [1:0] METH_PWM   = 2'h2;

    // Values after reset
    localparam logic [4:0]  RST_CTRL  = 5'h02;
    localparam logic [15:0] RST_SETPT = 16'h00D2;
    localparam logic [15:0] RST_HYST  = 16'h0505;
    localparam logic [7:0]  RST_PBAND = 8'h32;
    localparam logic [15:0] RST_ITIME = 16'h2328;
    localparam logic [15:0] RST_CYCLE = 16'h0384;
    localparam logic [15:0] RST_SENDP = 16'h003C;

    // Full-scale output in percent
    localparam logic [7:0] FULL_SCALE = 8'h64;

    // Sampling tick timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int TICK_PERIOD_MS = 1000;
    localparam int TICK_CYCLES    = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Heating or cooling direction
    typedef enum logic [1:0] {
        DIR_HEAT = 2'b01,
        DIR_COOL = 2'b10
    } rtc_dir_t;

endpackage

// file: design/rtc_top.sv
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// R1: Heat, cool, or automatic heat/cool switchover
// R2: Percent or on/off, sent cyclically or on change
// R3: Heating on below setpoint minus heat hysteresis
// R4: Heating off once temperature reaches setpoint
// R5: Cooling on above setpoint plus cool hysteresis
// R6: Cooling off once temperature falls to setpoint
// R7: Separate heating and cooling hysteresis values
// R8: Output is gain times error plus integral
// R9: Error sign depends on heating or cooling
// R10: Full output when error equals proportional band
// R11: Integral repeats proportional part each integral time
// R12: Pulse on time proportional to control value
// R13: Setpoint change restarts pulse cycle, recomputes output
// R14: Configure short cycles for low-inertia rooms
// R15: Clamp output; freeze integrator while saturated
// R16: Periodic tick drives integrator; reset clears state
module rtc_top #(
    parameter int TICK_CYC = rtc_pkg::TICK_CYCLES
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       ce,
    input  wire logic signed [15:0]         meas_temp,
    input  wire logic [rtc_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    input  wire logic [rtc_pkg::ADDR_W-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    output logic                            cmd_valid,
    output logic                            cmd_on,
    output logic [7:0]                      cmd_percent,
    output logic                            cmd_cooling
);
    import rtc_pkg::*;

    // Bus slave state
    logic              aw_got_ff;   // Write address held
    logic [ADDR_W-1:0] aw_addr_ff;  // Held write address
    logic              w_got_ff;    // Write data held
    logic [31:0]       w_data_ff;   // Held write data
    logic [3:0]        w_strb_ff;   // Held byte enables
    logic              bvalid_ff;   // Write answer pending
    logic [1:0]        bresp_ff;    // Write answer code
    logic              rvalid_ff;   // Read answer pending
    logic [31:0]       rdata_ff;    // Read answer data
    logic [1:0]        rresp_ff;    // Read answer code
    logic              do_write;    // Both halves present

    // Configuration registers
    logic [4:0]         ctrl_ff;    // Mode, method, send style
    logic signed [15:0] setpt_ff;   // Setpoint
    logic [15:0]        hyst_ff;    // Cool in upper byte, heat in lower
    logic [7:0]         pband_ff;   // Proportional band
    logic [15:0]        itime_ff;   // Integral time
    logic [15:0]        cycle_ff;   // Pulse-width period
    logic [15:0]        sendp_ff;   // Cyclic send period
    logic [31:0]        nxt_wval;   // Write data merged by strobes
    logic               sp_change;  // Setpoint write with new value

    // Control state
    rtc_dir_t           dir_ff;       // Current direction
    rtc_dir_t           nxt_dir;      // Direction for next cycle
    logic               tp_on_ff;     // Two-point output
    logic signed [39:0] acc_ff;       // Error times 100, summed per tick
    logic [31:0]        tick_cnt_ff;  // Sampling prescaler
    logic               tick;         // One-cycle sampling pulse
    logic [15:0]        pwm_cnt_ff;   // Ticks into the cycle
    logic [15:0]        on_ticks_ff;  // On length of this cycle
    logic               restart_ff;   // Latch new on length next cycle
    logic [15:0]        send_cnt_ff;  // Ticks since last cyclic send
    logic [7:0]         last_pct_ff;  // Last sent value
    logic               last_cool_ff; // Last sent direction
    logic               cmd_valid_ff; // Send pulse
    logic               cmd_on_ff;    // Sent on/off
    logic [7:0]         cmd_pct_ff;   // Sent percent
    logic               cmd_cool_ff;  // Sent direction

    // Decoded configuration
    logic [1:0] opm;
    logic [1:0] meth;
    logic       heat_sel;
    assign opm      = ctrl_ff[CTRL_OPM_LSB +: 2];
    assign meth     = ctrl_ff[CTRL_METH_LSB +: 2];
    assign heat_sel = (dir_ff == DIR_HEAT);

    // Byte-enable merge of write data into a register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Handshakes stall while the clock enable is low
    assign awready = ce && !aw_got_ff && !bvalid_ff;
    assign wready  = ce && !w_got_ff && !bvalid_ff;
    assign arready = ce && !rvalid_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign rvalid  = rvalid_ff;
    assign rdata   = rdata_ff;
    assign rresp   = rresp_ff;
    assign do_write = ce && aw_got_ff && w_got_ff && !bvalid_ff;

    // Merge source picked by address so the setpoint compare sees the new value
    always_comb begin
        nxt_wval = 32'h0000_0000;
        case (aw_addr_ff)
            OFS_CTRL:  nxt_wval = merge({27'h0, ctrl_ff}, w_data_ff, w_strb_ff);
            OFS_SETPT: nxt_wval = merge({16'h0, setpt_ff}, w_data_ff, w_strb_ff);
            OFS_HYST:  nxt_wval = merge({16'h0, hyst_ff}, w_data_ff, w_strb_ff);
            OFS_PBAND: nxt_wval = merge({24'h0, pband_ff}, w_data_ff, w_strb_ff);
            OFS_ITIME: nxt_wval = merge({16'h0, itime_ff}, w_data_ff, w_strb_ff);
            OFS_CYCLE: nxt_wval = merge({16'h0, cycle_ff}, w_data_ff, w_strb_ff);
            OFS_SENDP: nxt_wval = merge({16'h0, sendp_ff}, w_data_ff, w_strb_ff);
            default:   nxt_wval = 32'h0000_0000;
        endcase
    end
    assign sp_change = do_write && (aw_addr_ff == OFS_SETPT) && (nxt_wval[15:0] != setpt_ff);

    // Write channel capture and answer; address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff  <= 1'b0;
            aw_addr_ff <= '0;
            w_got_ff   <= 1'b0;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_got_ff  <= 1'b1;
                aw_addr_ff <= awaddr;
            end
            if (wvalid && wready) begin
                w_got_ff  <= 1'b1;
                w_data_ff <= wdata;
                w_strb_ff <= wstrb;
            end
            if (do_write) begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                // Status and holes refuse writes with an error
                bresp_ff  <= (aw_addr_ff <= OFS_SENDP && aw_addr_ff[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_ff && bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Configuration registers; only aligned mapped words change
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff  <= RST_CTRL;
            setpt_ff <= RST_SETPT;
            hyst_ff  <= RST_HYST;
            pband_ff <= RST_PBAND;
            itime_ff <= RST_ITIME;
            cycle_ff <= RST_CYCLE;
            sendp_ff <= RST_SENDP;
        end else if (do_write) begin
            case (aw_addr_ff)
                OFS_CTRL:  ctrl_ff  <= nxt_wval[4:0];
                OFS_SETPT: setpt_ff <= nxt_wval[15:0];
                OFS_HYST:  hyst_ff  <= nxt_wval[15:0];  // see R7
                OFS_PBAND: pband_ff <= nxt_wval[7:0];
                OFS_ITIME: itime_ff <= nxt_wval[15:0];
                OFS_CYCLE: cycle_ff <= nxt_wval[15:0];
                OFS_SENDP: sendp_ff <= nxt_wval[15:0];
                default:   ctrl_ff  <= ctrl_ff;
            endcase
        end
    end

    // Control arithmetic
    logic signed [16:0] err;       // Positive means demand
    logic signed [39:0] p_num;     // Error times 100
    logic signed [39:0] u_raw;     // Unclamped percent
    logic [15:0]        itime_div; // Zero guarded
    logic [7:0]         pband_div; // Zero guarded
    logic [15:0]        cycle_len; // Zero guarded
    logic [7:0]         pct;       // Clamped percent
    logic               freeze;    // Anti-windup hold
    logic [15:0]        on_calc;   // On length for the present value
    assign itime_div = (itime_ff == 16'h0000) ? 16'h0001 : itime_ff;
    assign pband_div = (pband_ff == 8'h00) ? 8'h01 : pband_ff;
    assign cycle_len = (cycle_ff == 16'h0000) ? 16'h0001 : cycle_ff;
    // Error direction follows the active direction, see R9
    assign err   = heat_sel ? 17'(setpt_ff) - 17'(meas_temp) : 17'(meas_temp) - 17'(setpt_ff);
    assign p_num = 40'(err) * 40'sd100;
    // Full scale at error equal to band; integral adds one p_num per itime ticks, see R8 R10 R11
    assign u_raw = (p_num + acc_ff / $signed({24'h00_0000, itime_div})) / $signed({32'h0000_0000, pband_div});
    assign pct   = (u_raw < 0) ? 8'h00 : (u_raw > 40'(FULL_SCALE)) ? FULL_SCALE : u_raw[7:0];  // see R15
    assign freeze = (u_raw >= 40'(FULL_SCALE) && err > 0) || (u_raw <= 0 && err < 0);
    assign on_calc = 16'((24'(pct) * 24'(cycle_len)) / 24'(FULL_SCALE));  // see R12

    // Sampling tick prescaler
    assign tick = (tick_cnt_ff == 32'(TICK_CYC - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_ff <= 32'h0000_0000;
        end else if (ce) begin
            tick_cnt_ff <= tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;  // see R16
        end
    end

    // Direction machine; automatic mode switches on the sign of the deviation
    always_comb begin
        nxt_dir = dir_ff;
        case (dir_ff)
            DIR_HEAT: begin
                if (opm == OPM_COOL || (opm == OPM_AUTO && meas_temp > setpt_ff)) begin
                    nxt_dir = DIR_COOL;  // see R1
                end
            end
            DIR_COOL: begin
                if (opm == OPM_HEAT || (opm == OPM_AUTO && meas_temp < setpt_ff)) begin
                    nxt_dir = DIR_HEAT;  // see R1
                end
            end
            default: nxt_dir = DIR_HEAT;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_ff <= DIR_HEAT;
        end else if (ce) begin
            dir_ff <= nxt_dir;
        end
    end

    // Two-point output; dead band between the thresholds holds the state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tp_on_ff <= 1'b0;
        end else if (ce) begin
            if (nxt_dir != dir_ff) begin
                tp_on_ff <= 1'b0;
            end else if (heat_sel) begin
                if (18'(meas_temp) < 18'(setpt_ff) - $signed(18'(hyst_ff[7:0]))) begin
                    tp_on_ff <= 1'b1;  // see R3
                end else if (meas_temp >= setpt_ff) begin
                    tp_on_ff <= 1'b0;  // see R4
                end
            end else begin
                if (18'(meas_temp) > 18'(setpt_ff) + $signed(18'(hyst_ff[15:8]))) begin
                    tp_on_ff <= 1'b1;  // see R5
                end else if (meas_temp <= setpt_ff) begin
                    tp_on_ff <= 1'b0;  // see R6
                end
            end
        end
    end

    // Integrator; cleared on direction change since the error flips sign
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_ff <= 40'sh00_0000_0000;  // see R16
        end else if (ce) begin
            if (nxt_dir != dir_ff) begin
                acc_ff <= 40'sh00_0000_0000;
            end else if (tick && !freeze) begin
                acc_ff <= acc_ff + p_num;  // see R11 R15
            end
        end
    end

    // Pulse-width cycle; a new setpoint is applied one cycle after the restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_cnt_ff  <= 16'h0000;
            on_ticks_ff <= 16'h0000;
            restart_ff  <= 1'b0;
        end else if (ce) begin
            restart_ff <= sp_change;
            if (sp_change) begin
                pwm_cnt_ff <= 16'h0000;  // see R13
            end else if (restart_ff) begin
                on_ticks_ff <= on_calc;  // see R13
            end else if (tick) begin
                if (pwm_cnt_ff >= cycle_len - 16'h0001) begin
                    pwm_cnt_ff  <= 16'h0000;
                    on_ticks_ff <= on_calc;  // see R12
                end else begin
                    pwm_cnt_ff <= pwm_cnt_ff + 16'h0001;
                end
            end
        end
    end

    // Command value for the actuator
    logic       cur_on;
    logic [7:0] cur_pct;
    logic       send_tick;
    logic       send_now;
    assign cur_on    = (meth == METH_PWM) ? (pwm_cnt_ff < on_ticks_ff) : tp_on_ff;
    assign cur_pct   = (meth == METH_PI) ? pct : (cur_on ? FULL_SCALE : 8'h00);  // see R2
    assign send_tick = tick && (send_cnt_ff >= sendp_ff - 16'h0001);
    assign send_now  = ctrl_ff[CTRL_CYC_BIT] ? send_tick
                     : (cur_pct != last_pct_ff || !heat_sel != last_cool_ff);  // see R2

    // Send scheduling and registered command outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            send_cnt_ff  <= 16'h0000;
            last_pct_ff  <= 8'h00;
            last_cool_ff <= 1'b0;
            cmd_valid_ff <= 1'b0;
            cmd_on_ff    <= 1'b0;
            cmd_pct_ff   <= 8'h00;
            cmd_cool_ff  <= 1'b0;
        end else if (ce) begin
            cmd_valid_ff <= send_now;
            if (tick) begin
                send_cnt_ff <= send_tick ? 16'h0000 : send_cnt_ff + 16'h0001;
            end
            if (send_now) begin
                last_pct_ff  <= cur_pct;
                last_cool_ff <= !heat_sel;
                cmd_on_ff    <= (cur_pct != 8'h00);
                cmd_pct_ff   <= cur_pct;
                cmd_cool_ff  <= !heat_sel;
            end
        end
    end
    assign cmd_valid   = cmd_valid_ff;
    assign cmd_on      = cmd_on_ff;
    assign cmd_percent = cmd_pct_ff;
    assign cmd_cooling = cmd_cool_ff;

    // Read channel; status reflects live control state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid_ff <= 1'b1;
                rresp_ff  <= RESP_OKAY;
                case (araddr)
                    OFS_CTRL:   rdata_ff <= {27'h0, ctrl_ff};
                    OFS_SETPT:  rdata_ff <= {16'h0, setpt_ff};
                    OFS_HYST:   rdata_ff <= {16'h0, hyst_ff};
                    OFS_PBAND:  rdata_ff <= {24'h0, pband_ff};
                    OFS_ITIME:  rdata_ff <= {16'h0, itime_ff};
                    OFS_CYCLE:  rdata_ff <= {16'h0, cycle_ff};
                    OFS_SENDP:  rdata_ff <= {16'h0, sendp_ff};
                    OFS_STATUS: rdata_ff <= {16'h0, pct, 5'h0, freeze, !heat_sel, cur_on};
                    default: begin
                        rdata_ff <= 32'h0000_0000;
                        rresp_ff <= RESP_SLVERR;
                    end
                endcase
            end else if (rvalid_ff && rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Checks on the control behaviour
    a_heat_on_thresh: assert property (@(posedge aclk) disable iff (!aresetn)  // see R3
        ce && heat_sel && nxt_dir == dir_ff && 18'(meas_temp) < 18'(setpt_ff) - $signed(18'(hyst_ff[7:0])) |=> tp_on_ff)
        else $error("heating did not switch on");
    a_heat_off_thresh: assert property (@(posedge aclk) disable iff (!aresetn)  // see R4
        ce && heat_sel && meas_temp >= setpt_ff |=> !tp_on_ff)
        else $error("heating did not switch off");
    a_cool_on_thresh: assert property (@(posedge aclk) disable iff (!aresetn)  // see R5
        ce && !heat_sel && nxt_dir == dir_ff && 18'(meas_temp) > 18'(setpt_ff) + $signed(18'(hyst_ff[15:8])) |=> tp_on_ff)
        else $error("cooling did not switch on");
    a_cool_off_thresh: assert property (@(posedge aclk) disable iff (!aresetn)  // see R6
        ce && !heat_sel && meas_temp <= setpt_ff |=> !tp_on_ff)
        else $error("cooling did not switch off");
    a_auto_to_cool: assert property (@(posedge aclk) disable iff (!aresetn)  // see R1
        ce && opm == OPM_AUTO && meas_temp > setpt_ff |=> dir_ff == DIR_COOL)
        else $error("automatic switchover to cooling missed");
    a_pct_clamped: assert property (@(posedge aclk) disable iff (!aresetn)  // see R15
        pct <= FULL_SCALE && (u_raw >= 40'(FULL_SCALE) -> pct == FULL_SCALE))
        else $error("control value out of range");
    a_integ_freeze: assert property (@(posedge aclk) disable iff (!aresetn)  // see R15
        ce && tick && freeze && nxt_dir == dir_ff |=> $stable(acc_ff))
        else $error("integrator moved while saturated");
    a_pwm_restart: assert property (@(posedge aclk) disable iff (!aresetn)  // see R13
        ce && sp_change |=> pwm_cnt_ff == 16'h0000 && restart_ff ##1 ce |-> on_ticks_ff == $past(on_calc))
        else $error("setpoint change did not restart the cycle");
    a_pwm_wrap: assert property (@(posedge aclk) disable iff (!aresetn)  // see R12
        ce && tick && !sp_change && !restart_ff && pwm_cnt_ff >= cycle_len - 16'h0001 |=> pwm_cnt_ff == 16'h0000)
        else $error("cycle did not wrap at its length");
    a_reset_clear: assert property (@(posedge aclk)  // see R16
        !aresetn |=> acc_ff == 40'sh00_0000_0000 && pwm_cnt_ff == 16'h0000 && !cmd_valid)
        else $error("reset left control state");
    a_event_send: assert property (@(posedge aclk) disable iff (!aresetn)  // see R2
        ce && !ctrl_ff[CTRL_CYC_BIT] && cur_pct != last_pct_ff |=> cmd_valid && cmd_percent == $past(cur_pct))
        else $error("changed value was not sent");

endmodule

// file: verif/rtc_actuator.sv
`timescale 1ns/1ps
// Far-side actuator; it cannot stall, so it only latches what it is sent
module rtc_actuator (
    input  wire logic       aclk,
    input  wire logic       cmd_valid,
    input  wire logic       cmd_on,
    input  wire logic [7:0] cmd_percent,
    input  wire logic       cmd_cooling,
    output logic [7:0]      heat_ff,
    output logic [7:0]      cool_ff
);
    // Latch the command for the addressed side; percent and on/off both fit here
    always @(posedge aclk) begin
        if (cmd_valid === 1'b1) begin
            if (cmd_cooling) cool_ff <= cmd_on ? cmd_percent : 8'h00;
            else heat_ff <= cmd_on ? cmd_percent : 8'h00;
        end
    end
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rtc_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic signed [15:0] meas_temp = 16'sh00D2;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, cmd_percent, h_pct, c_pct;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, arready, bvalid, rvalid, cmd_valid, cmd_on, cmd_cooling;
    logic [9:0]  exp_q[$];  // Expected {cooling, on, percent}
    int          n_errors = 0, compares = 0, k;
    always #25 aclk = ~aclk;
    rtc_top #(.TICK_CYC(4)) rtc_top_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .meas_temp(meas_temp),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .cmd_valid(cmd_valid),
        .cmd_on(cmd_on), .cmd_percent(cmd_percent), .cmd_cooling(cmd_cooling));
    rtc_actuator rtc_actuator_i (.aclk(aclk), .cmd_valid(cmd_valid), .cmd_on(cmd_on),
        .cmd_percent(cmd_percent), .cmd_cooling(cmd_cooling), .heat_ff(h_pct), .cool_ff(c_pct));
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wrap_up;
        if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Write: both channels offered together, each released when taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 0;
        wd = 0;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin ad = 1; awvalid <= 0; end
            if (!wd && wready === 1'b1) begin wd = 1; wvalid <= 0; end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 0;
        chk("bresp", bresp, RESP_OKAY);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 0;
        chk("rdata", rdata, e);
        chk("rresp", rresp, er);
    endtask
    // Step the temperature; optionally note the command it must cause
    task setm(input logic signed [15:0] v, input logic x, input logic [9:0] e);
        if (x) exp_q.push_back(e);
        meas_temp <= v;
        repeat (8) @(posedge aclk);
    endtask
    // Watcher: each command pulse consumes the oldest note
    always @(posedge aclk) begin
        if (cmd_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected cmd", 1, 0);
            else chk("cmd", {cmd_cooling, cmd_on, cmd_percent}, exp_q.pop_front());
        end
    end
    initial begin
        repeat (5000) @(posedge aclk);
        n_errors++;
        wrap_up;
    end
    initial begin
        k = $urandom(7909);
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        rd(OFS_CTRL, 32'h02, RESP_OKAY);
        rd(OFS_SETPT, 32'hD2, RESP_OKAY);
        rd(OFS_HYST, 32'h0505, RESP_OKAY);
        rd(8'h20, 32'h0, RESP_SLVERR);
        wr(OFS_CTRL, 32'h0); // Heating, two-point, on change
        repeat (4) @(posedge aclk);
        setm(16'sd205, 0, 0); // At threshold, stays off
        setm(16'sd204, 1, 10'h164);
        setm(16'sd209, 0, 0);
        setm(16'sd210, 1, 10'h000);
        wr(OFS_HYST, 32'h0302); // Cool 3, heat 2
        rd(OFS_HYST, 32'h0302, RESP_OKAY);
        exp_q.push_back(10'h200); // Direction now cooling, off
        wr(OFS_CTRL, 32'h1);
        repeat (8) @(posedge aclk);
        setm(16'sd213, 0, 0);
        setm(16'sd214, 1, 10'h364);
        for (k = 0; k < 8; k++) setm(16'sd211 + 16'($urandom % 3), 0, 0);
        setm(16'sd210, 1, 10'h200);
        for (k = 0; k < 6; k++) setm(16'sd207 + 16'($urandom % 7), 0, 0);
        setm(16'sd210, 0, 0); // Back at setpoint, cooling stays off
        wr(OFS_CYCLE, 32'h000C); // Short cycle for a low-inertia room
        rd(OFS_CYCLE, 32'h000C, RESP_OKAY);
        wr(OFS_CTRL, 32'h5); // Cooling, continuous, on change
        repeat (4) @(posedge aclk);
        setm(16'sd215, 1, 10'h30A); // 0.5 K of a 5 K band gives 10 percent
        exp_q.push_back(10'h314); // 1.0 K of 5 K band gives 20 percent
        wr(OFS_SETPT, 32'h00CD); // Setpoint change also restarts the pulse cycle
        repeat (4) @(posedge aclk);
        rd(OFS_STATUS, 32'h0000_1403, RESP_OKAY); // Percent 20, cooling, two-point on
        chk("pending", exp_q.size(), 0);
        wrap_up;
    end
endmodule
